// [hdl/host_memory_port_dev.sv]
// Function
// - latch phase: select low, latch strobe high
// - capture address from bus at latch end
// - host ends latch before any access
// - write: select and write strobe both low
// - host starts only while acknowledge low
// - acknowledge high promptly on access start
// - write acknowledge low no sooner than 1.5 tCK
// - short write: data taken at strobe end
// - long write: data valid half tCK before end
// - read: select and read strobe both low
// - drive previous word, hold 2 or 1 tCK
// - new word on bus half tCK before ack
// - program word read as two halves
// - release bus shortly after read end
// - short-read-only mode keeps previous data driven
`timescale 1ns/1ps
module host_memory_port_dev (
   input  wire logic                                     ref_clk,
   input  wire logic                                     sys_rst,
   host_memory_port_if.device                            link,
   input  wire logic                                     sro_set,
   input  wire logic                                     sro_clr,
   output logic                                          short_read_only,
   output logic                                          mem_rd,
   output logic                                          mem_wr,
   output logic                                          mem_prog_sel,
   output logic [13:0]                                   mem_addr,
   output logic [host_memory_port_pkg::PROG_W-1:0]       mem_wdata,
   input  wire logic [host_memory_port_pkg::PROG_W-1:0]  mem_rdata
);
   import host_memory_port_pkg::*;

   typedef struct packed {
      dev_state_type st;
      logic [7:0]    cnt;
      logic [15:0]   addr;
      logic          half;    // 1 = second half of program word
      logic          ended;   // strobe already released
      logic [15:0]   prev;    // previously fetched word
      logic [7:0]    lobuf;   // low byte of fetched program word
      logic [15:0]   wbuf;    // first half of program write
      logic [15:0]   wdat;    // data sampled while write active
      logic          ack_n;
      logic [15:0]   bus_out;
      logic          oe_n;
      logic          rd;
      logic          wr;
      logic [23:0]   wdata;
      logic          sro;
      logic [15:0]   maddr;   // address of the memory access
   } dev_regs_type;

   dev_regs_type r_ff;
   dev_regs_type nxt_r;

   logic latch_act;
   logic wr_act;
   logic rd_act;
   logic is_prog;

   // ****************************************************************
   // access decode
   // ****************************************************************
   assign latch_act = !link.port_select_n
                      && link.address_latch_strobe;
   assign wr_act    = !link.port_select_n
                      && !link.host_write_strobe_n;
   assign rd_act    = !link.port_select_n
                      && !link.host_read_strobe_n;
   assign is_prog   = r_ff.addr[SPACE_BIT];

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      nxt_r    = r_ff;
      nxt_r.rd = 1'b0;
      nxt_r.wr = 1'b0;
      // short-read-only bit, core set wins over clear
      if (sro_set) begin
         nxt_r.sro = 1'b1;
      end else if (sro_clr) begin
         nxt_r.sro = 1'b0;
      end
      if (r_ff.cnt != 8'h00) begin
         nxt_r.cnt = r_ff.cnt - 8'h01;
      end
      case (r_ff.st)
         DEV_IDLE: begin
            // port free: acknowledge low while idle
            nxt_r.ack_n = 1'b0;
            nxt_r.ended = 1'b0;
            if (latch_act) begin
               nxt_r.st   = DEV_LATCH;
               nxt_r.wdat = link.muxed_addr_data_bus;
            end else if (wr_act) begin
               nxt_r.st    = DEV_WRITE;
               nxt_r.ack_n = 1'b1;
               nxt_r.wdat  = link.muxed_addr_data_bus;
               nxt_r.cnt   = 8'(ACK_LOW_MIN_CYC - 1);
            end else if (rd_act) begin
               nxt_r.st      = DEV_RD_HOLD;
               nxt_r.ack_n   = 1'b1;
               nxt_r.bus_out = r_ff.prev;
               nxt_r.oe_n    = 1'b0;
               nxt_r.cnt     = r_ff.half ? 8'(HOLD_HALF_CYC - 1)
                                         : 8'(HOLD_FULL_CYC - 1);
            end
         end
         DEV_LATCH: begin
            // last sample before the end edge is the address
            if (latch_act) begin
               nxt_r.wdat = link.muxed_addr_data_bus;
            end else begin
               nxt_r.addr = r_ff.wdat;
               nxt_r.half = 1'b0;
               nxt_r.st   = DEV_IDLE;
            end
         end
         DEV_WRITE, DEV_WAIT_END: begin
            if (r_ff.st == DEV_WRITE && r_ff.cnt == 8'h00) begin
               // minimum busy time met: port free again
               nxt_r.ack_n = 1'b0;
               nxt_r.st    = r_ff.ended ? DEV_IDLE : DEV_WAIT_END;
            end
            if (wr_act) begin
               nxt_r.wdat = link.muxed_addr_data_bus;
            end else if (rd_act) begin
               nxt_r.ended = 1'b0;
            end else if (!r_ff.ended) begin
               nxt_r.ended = 1'b1;
               nxt_r.oe_n  = 1'b1;
               if (r_ff.st == DEV_WAIT_END && !r_ff.oe_n) begin
                  nxt_r.st = DEV_IDLE;
               end
               if (r_ff.oe_n) begin
                  // strobe end of a write: take sampled data
                  if (is_prog && !r_ff.half) begin
                     nxt_r.wbuf = r_ff.wdat;
                     nxt_r.half = 1'b1;
                  end else begin
                     nxt_r.wr    = 1'b1;
                     nxt_r.wdata = is_prog ? {r_ff.wbuf, r_ff.wdat[7:0]}
                                           : {8'h00, r_ff.wdat};
                     nxt_r.half  = 1'b0;
                     nxt_r.addr  = r_ff.addr + 16'h0001;
                  end
                  // an end that meets the busy-time end must not stick
                  if (nxt_r.st == DEV_WAIT_END) begin
                     nxt_r.st = DEV_IDLE;
                  end
               end
            end
         end
         DEV_RD_HOLD: begin
            if (!rd_act && !r_ff.ended) begin
               nxt_r.ended = 1'b1;
               nxt_r.oe_n  = 1'b1;
            end
            if (r_ff.cnt == 8'h00) begin
               if (is_prog && r_ff.half) begin
                  // second half comes from the buffered low byte
                  nxt_r.prev = {8'h00, r_ff.lobuf};
                  nxt_r.st   = DEV_RD_SETUP;
                  // word reaches the bus one cycle after entry
                  nxt_r.cnt  = 8'(DATA_SETUP_CYC);
               end else begin
                  nxt_r.rd  = 1'b1;
                  nxt_r.st  = DEV_RD_FETCH;
                  nxt_r.cnt = 8'h01;
               end
            end
         end
         DEV_RD_FETCH: begin
            if (!rd_act && !r_ff.ended) begin
               nxt_r.ended = 1'b1;
               nxt_r.oe_n  = 1'b1;
            end
            if (r_ff.cnt == 8'h00) begin
               nxt_r.prev  = is_prog ? mem_rdata[23:8] : mem_rdata[15:0];
               nxt_r.lobuf = mem_rdata[7:0];
               nxt_r.st    = DEV_RD_SETUP;
               nxt_r.cnt   = 8'(DATA_SETUP_CYC);
            end
         end
         DEV_RD_SETUP: begin
            // new word on the bus unless previous data must stay
            if (!r_ff.ended && !r_ff.sro) begin
               nxt_r.bus_out = r_ff.prev;
            end
            if (!rd_act && !r_ff.ended) begin
               nxt_r.ended = 1'b1;
               nxt_r.oe_n  = 1'b1;
            end
            if (r_ff.cnt == 8'h00 && r_ff.bus_out == r_ff.prev
                || r_ff.cnt == 8'h00 && (r_ff.ended || r_ff.sro)) begin
               nxt_r.ack_n = 1'b0;
               if (is_prog && !r_ff.half) begin
                  nxt_r.half = 1'b1;
               end else begin
                  nxt_r.half = 1'b0;
                  nxt_r.addr = r_ff.addr + 16'h0001;
               end
               nxt_r.st = (r_ff.ended || !rd_act) ? DEV_IDLE
                                                  : DEV_WAIT_END;
            end
         end
         default: begin
            nxt_r.st = DEV_IDLE;
         end
      endcase
      // a read that ends in the wait-end state releases the bus
      if (r_ff.st == DEV_WAIT_END && !r_ff.oe_n && !rd_act) begin
         nxt_r.oe_n = 1'b1;
         nxt_r.st   = DEV_IDLE;
      end
      // memory address lags the advance so a write lands where aimed
      nxt_r.maddr = nxt_r.wr ? r_ff.addr : nxt_r.addr;
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         r_ff         <= '0;
         r_ff.st      <= DEV_IDLE;
         r_ff.addr    <= ADDR_RST;
         r_ff.bus_out <= BUS_IDLE;
         r_ff.oe_n    <= 1'b1;
         r_ff.ack_n   <= 1'b1;
         r_ff.sro     <= 1'b0;
         r_ff.maddr   <= ADDR_RST;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // ****************************************************************
   // outputs, straight from flops
   // ****************************************************************
   assign link.port_acknowledge_n = r_ff.ack_n;
   assign link.dev_bus_out        = r_ff.bus_out;
   assign link.dev_bus_oe_n       = r_ff.oe_n;
   assign short_read_only         = r_ff.sro;
   assign mem_rd                  = r_ff.rd;
   assign mem_wr                  = r_ff.wr;
   assign mem_prog_sel            = r_ff.maddr[SPACE_BIT];
   assign mem_addr                = r_ff.maddr[13:0];
   assign mem_wdata               = r_ff.wdata;

endmodule : host_memory_port_dev

// [pkg/host_memory_port_pkg.sv]
package host_memory_port_pkg;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_PERIOD_NS = 4;    // ref_clk period
   localparam int T_CK_NS       = 20;   // internal instruction cycle
   // write ack low no earlier than 1.5 tCK (least time, round up)
   localparam int ACK_LOW_MIN_CYC =
      (3 * T_CK_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
   // previous data hold: 2 tCK for data/first half, tCK for second half
   localparam int HOLD_FULL_CYC = (2 * T_CK_NS) / CLK_PERIOD_NS;
   localparam int HOLD_HALF_CYC = T_CK_NS / CLK_PERIOD_NS;
   // new read data stands 0.5 tCK before ack low (least, round up)
   localparam int DATA_SETUP_CYC =
      (T_CK_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
   // host: least strobe width 10 ns
   localparam int STROBE_MIN_NS  = 10;
   localparam int STROBE_MIN_CYC =
      (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ****************************************************************
   // layout and reset values
   // ****************************************************************
   localparam int          BUS_W          = 16;
   localparam int          PROG_W         = 24;
   localparam int          SPACE_BIT      = 14;  // 1 = program memory
   localparam int          SRO_BIT        = 14;  // short-read-only bit
   localparam logic [15:0] ADDR_RST       = 16'h0000;
   localparam logic [15:0] BUS_IDLE       = 16'hffff;

   // ****************************************************************
   // state encodings
   // ****************************************************************
   typedef enum logic [2:0] {
      DEV_IDLE     = 3'b000,
      DEV_LATCH    = 3'b001,
      DEV_WRITE    = 3'b011,
      DEV_RD_HOLD  = 3'b010,
      DEV_RD_FETCH = 3'b110,
      DEV_RD_SETUP = 3'b111,
      DEV_WAIT_END = 3'b101
   } dev_state_type;

   typedef enum logic [2:0] {
      HST_IDLE     = 3'b000,
      HST_WAIT_FREE= 3'b001,
      HST_STROBE   = 3'b011,
      HST_WAIT_BSY = 3'b010,
      HST_WAIT_ACK = 3'b110,
      HST_RELEASE  = 3'b111
   } host_state_type;

   typedef enum logic [1:0] {
      OP_LATCH = 2'h0,
      OP_WRITE = 2'h1,
      OP_READ  = 2'h2
   } host_op_type;

endpackage : host_memory_port_pkg

// [pkg/host_memory_port_if.sv]
`timescale 1ns/1ps
interface host_memory_port_if;
   logic        port_select_n;
   logic        address_latch_strobe;
   logic        host_read_strobe_n;
   logic        host_write_strobe_n;
   logic        port_acknowledge_n;
   logic [15:0] host_bus_out;
   logic        host_bus_oe_n;
   logic [15:0] dev_bus_out;
   logic        dev_bus_oe_n;
   logic [15:0] muxed_addr_data_bus;

   // resolved bus level; undriven lines are pulled high
   assign muxed_addr_data_bus = !dev_bus_oe_n  ? dev_bus_out  :
                                !host_bus_oe_n ? host_bus_out :
                                16'hffff;

   modport device (
      input  port_select_n, address_latch_strobe, host_read_strobe_n,
      input  host_write_strobe_n, muxed_addr_data_bus,
      output port_acknowledge_n, dev_bus_out, dev_bus_oe_n
   );

   modport host (
      output port_select_n, address_latch_strobe, host_read_strobe_n,
      output host_write_strobe_n, host_bus_out, host_bus_oe_n,
      input  port_acknowledge_n, muxed_addr_data_bus
   );
endinterface : host_memory_port_if

// [hdl/host_memory_port_host.sv]
`timescale 1ns/1ps
module host_memory_port_host (
   input  wire logic                       ref_clk,
   input  wire logic                       sys_rst,
   host_memory_port_if.host                link,
   input  wire logic                       cmd_valid,
   input  wire host_memory_port_pkg::host_op_type cmd_op,
   input  wire logic [15:0]                cmd_data,
   output logic                            cmd_ready,
   output logic                            rsp_valid,
   output logic [15:0]                     rsp_data
);
   import host_memory_port_pkg::*;

   typedef struct packed {
      host_state_type st;
      host_op_type    op;
      logic [7:0]     cnt;
      logic           sel_n;
      logic           als;
      logic           rd_n;
      logic           wr_n;
      logic [15:0]    bus_out;
      logic           oe_n;
      logic           ready;
      logic           rvalid;
      logic [15:0]    rdata;
   } host_regs_type;

   host_regs_type r_ff;
   host_regs_type nxt_r;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      nxt_r        = r_ff;
      nxt_r.rvalid = 1'b0;
      if (r_ff.cnt != 8'h00) begin
         nxt_r.cnt = r_ff.cnt - 8'h01;
      end
      case (r_ff.st)
         HST_IDLE: begin
            nxt_r.ready = 1'b1;
            if (cmd_valid && r_ff.ready) begin
               nxt_r.ready   = 1'b0;
               nxt_r.op      = cmd_op;
               nxt_r.bus_out = cmd_data;
               nxt_r.st      = HST_WAIT_FREE;
            end
         end
         HST_WAIT_FREE: begin
            // start only on a free port
            if (!link.port_acknowledge_n) begin
               nxt_r.sel_n = 1'b0;
               nxt_r.cnt   = 8'(STROBE_MIN_CYC - 1);
               nxt_r.st    = HST_STROBE;
               case (r_ff.op)
                  OP_LATCH: begin
                     nxt_r.als  = 1'b1;
                     nxt_r.oe_n = 1'b0;
                  end
                  OP_WRITE: begin
                     nxt_r.wr_n = 1'b0;
                     nxt_r.oe_n = 1'b0;
                  end
                  default: begin
                     nxt_r.rd_n = 1'b0;
                  end
               endcase
            end
         end
         HST_STROBE: begin
            if (r_ff.cnt == 8'h00) begin
               if (r_ff.op == OP_LATCH) begin
                  // end latch before anything else, address held
                  nxt_r.als   = 1'b0;
                  nxt_r.sel_n = 1'b1;
                  nxt_r.st    = HST_RELEASE;
               end else begin
                  nxt_r.st = HST_WAIT_BSY;
               end
            end
         end
         HST_WAIT_BSY: begin
            if (link.port_acknowledge_n) begin
               nxt_r.st = HST_WAIT_ACK;
            end
         end
         HST_WAIT_ACK: begin
            // long cycles: strobe held past acknowledge low
            if (!link.port_acknowledge_n) begin
               nxt_r.sel_n = 1'b1;
               nxt_r.rd_n  = 1'b1;
               nxt_r.wr_n  = 1'b1;
               if (r_ff.op == OP_READ) begin
                  nxt_r.rdata  = link.muxed_addr_data_bus;
                  nxt_r.rvalid = 1'b1;
               end
               nxt_r.st = HST_RELEASE;
            end
         end
         HST_RELEASE: begin
            // data held one cycle past the strobe end
            nxt_r.oe_n = 1'b1;
            nxt_r.st   = HST_IDLE;
         end
         default: begin
            nxt_r.st = HST_IDLE;
         end
      endcase
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         r_ff         <= '0;
         r_ff.st      <= HST_IDLE;
         r_ff.op      <= OP_LATCH;
         r_ff.sel_n   <= 1'b1;
         r_ff.rd_n    <= 1'b1;
         r_ff.wr_n    <= 1'b1;
         r_ff.oe_n    <= 1'b1;
         r_ff.bus_out <= BUS_IDLE;
      end else begin
         r_ff <= nxt_r;
      end
   end

   assign link.port_select_n        = r_ff.sel_n;
   assign link.address_latch_strobe = r_ff.als;
   assign link.host_read_strobe_n   = r_ff.rd_n;
   assign link.host_write_strobe_n  = r_ff.wr_n;
   assign link.host_bus_out         = r_ff.bus_out;
   assign link.host_bus_oe_n        = r_ff.oe_n;
   assign cmd_ready                 = r_ff.ready;
   assign rsp_valid                 = r_ff.rvalid;
   assign rsp_data                  = r_ff.rdata;

endmodule : host_memory_port_host

// [testbench/host_memory_port_sva.sv]
`timescale 1ns/1ps
module host_memory_port_sva (
   input wire logic        ref_clk,
   input wire logic        sys_rst,
   input wire logic        port_select_n,
   input wire logic        address_latch_strobe,
   input wire logic        host_read_strobe_n,
   input wire logic        host_write_strobe_n,
   input wire logic        port_acknowledge_n,
   input wire logic [15:0] dev_bus_out,
   input wire logic        dev_bus_oe_n
);
   logic wr_act;
   logic rd_act;
   logic lat_act;

   // ****************************************************************
   // phase decode and checks
   // ****************************************************************
   // access phases as seen on the wire
   assign wr_act  = !port_select_n && !host_write_strobe_n;
   assign rd_act  = !port_select_n && !host_read_strobe_n;
   assign lat_act = !port_select_n && address_latch_strobe;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   a_ack_busy_wr: assert property (
      $rose(wr_act) |=> port_acknowledge_n)
      else $error("ack not raised on write start");
   a_ack_busy_rd: assert property (
      $rose(rd_act) |=> port_acknowledge_n)
      else $error("ack not raised on read start");
   a_write_ack_time: assert property ($rose(wr_act) |=>
      port_acknowledge_n[*7] ##[1:4] !port_acknowledge_n)
      else $error("write ack low too early or too late");
   a_prev_drive: assert property ($rose(rd_act) |=> !dev_bus_oe_n)
      else $error("previous word not driven at read start");
   a_prev_hold: assert property ($rose(rd_act) ##1 1 |=>
      $stable(dev_bus_out)[*3])
      else $error("previous word not held");
   a_data_before_ack: assert property (
      $fell(port_acknowledge_n) && rd_act
      |-> !dev_bus_oe_n && $stable(dev_bus_out)
      && dev_bus_out == $past(dev_bus_out, 3))
      else $error("read word not settled before ack");
   a_bus_release: assert property (
      $fell(rd_act) |-> ##[1:2] dev_bus_oe_n)
      else $error("bus not released after read");
   a_drive_in_read: assert property (!dev_bus_oe_n |->
      rd_act || $past(rd_act) || $past(rd_act, 2))
      else $error("bus driven outside a read");
   a_start_when_free: assert property (
      $rose(wr_act) || $rose(rd_act)
      || $rose(lat_act) |-> !$past(port_acknowledge_n))
      else $error("access started while busy");
   a_latch_first: assert property (
      $rose(wr_act) || $rose(rd_act) |-> !lat_act)
      else $error("access overlaps address latch");
   a_long_read: assert property (
      $fell(rd_act) |-> !$past(port_acknowledge_n))
      else $error("read ended before ack low");

   // main traffic kinds
   c_write: cover property ($rose(wr_act));
   c_read: cover property ($fell(port_acknowledge_n) && rd_act);
   c_latch: cover property ($fell(lat_act));
endmodule : host_memory_port_sva

// [testbench/host_dma_port_handshake_test.sv]
`timescale 1ns/1ps
module host_dma_port_handshake_test;
   import host_memory_port_pkg::*;
   logic        ref_clk;
   logic        sys_rst;
   logic        sro_set;
   logic        sro_clr;
   logic        short_read_only;
   logic        mem_rd;
   logic        mem_wr;
   logic        mem_prog_sel;
   logic [13:0] mem_addr;
   logic [23:0] mem_wdata;
   logic [23:0] mem_rdata;
   logic [23:0] data_mem [16];
   logic [23:0] prog_mem [16];
   logic        cmd_valid;
   host_op_type cmd_op;
   logic [15:0] cmd_data;
   logic        cmd_ready;
   logic        rsp_valid;
   logic [15:0] rsp_data;
   logic [15:0] v;
   int          fail_count;
   int          tests_run;

   host_memory_port_if bus ();

   host_memory_port_dev u_host_memory_port_dev (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .link(bus.device), .sro_set(sro_set),
      .sro_clr(sro_clr), .short_read_only(short_read_only),
      .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_prog_sel(mem_prog_sel),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   host_memory_port_host u_host_memory_port_host (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .link(bus.host), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data));

   host_memory_port_sva u_host_memory_port_sva (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .port_select_n(bus.port_select_n),
      .address_latch_strobe(bus.address_latch_strobe),
      .host_read_strobe_n(bus.host_read_strobe_n),
      .host_write_strobe_n(bus.host_write_strobe_n),
      .port_acknowledge_n(bus.port_acknowledge_n),
      .dev_bus_out(bus.dev_bus_out), .dev_bus_oe_n(bus.dev_bus_oe_n));

   // ****************************************************************
   // clock, memory model, tasks
   // ****************************************************************
   // 250 MHz reference clock
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // memory answers on the falling edge within the fetch strobe cycle
   always @(negedge ref_clk) begin
      if (mem_wr && mem_prog_sel) prog_mem[mem_addr[3:0]] <= mem_wdata;
      if (mem_wr && !mem_prog_sel) data_mem[mem_addr[3:0]] <= mem_wdata;
      if (mem_rd) mem_rdata <= mem_prog_sel ? prog_mem[mem_addr[3:0]] :
                                              data_mem[mem_addr[3:0]];
   end

   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop

   // hand one command to the host end once it is ready
   task automatic cmd(input host_op_type op, input logic [15:0] d);
      int n;
      n = 0;
      @(negedge ref_clk);
      while (cmd_ready !== 1'b1 && n < 300) begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 300) begin
         fail_count++;
         report_and_stop();
      end
      cmd_valid = 1'b1;
      cmd_op    = op;
      cmd_data  = d;
      @(negedge ref_clk);
      cmd_valid = 1'b0;
   endtask : cmd

   // long read, result taken with the host response pulse
   task automatic rd(output logic [15:0] r);
      int n;
      n = 0;
      cmd(OP_READ, 16'h0000);
      while (rsp_valid !== 1'b1 && n < 300) begin
         @(negedge ref_clk);
         n++;
      end
      if (n >= 300) begin
         fail_count++;
         report_and_stop();
      end
      r = rsp_data;
   endtask : rd

   // pulse the core-side mode controls
   task automatic sro(input logic s, input logic c);
      @(negedge ref_clk);
      sro_set = s;
      sro_clr = c;
      @(negedge ref_clk);
      sro_set = 1'b0;
      sro_clr = 1'b0;
   endtask : sro

   // ****************************************************************
   // test sequence
   // ****************************************************************
   // reset, data space, mode, program space
   initial begin
      fail_count = 0;
      tests_run  = 0;
      sys_rst    = 1'b1;
      sro_set    = 1'b0;
      sro_clr    = 1'b0;
      cmd_valid  = 1'b0;
      cmd_op     = OP_LATCH;
      cmd_data   = 16'h0000;
      mem_rdata  = 24'h000000;
      repeat (8) @(negedge ref_clk);
      sys_rst = 1'b0;
      repeat (2) @(negedge ref_clk);
      check({23'h0, bus.port_acknowledge_n}, 24'h0);
      check({23'h0, short_read_only}, 24'h0);
      check({23'h0, bus.dev_bus_oe_n}, 24'h1);
      $display("reset test done");
      cmd(OP_LATCH, 16'h0003);
      cmd(OP_WRITE, 16'h1234);
      cmd(OP_WRITE, 16'h5678);
      cmd(OP_WRITE, 16'h9abc);
      cmd(OP_LATCH, 16'h0003);
      rd(v);
      check({8'h0, v}, 24'h001234);
      sro(1'b1, 1'b0);
      check({23'h0, short_read_only}, 24'h1);
      rd(v);
      check({8'h0, v}, 24'h001234);
      sro(1'b1, 1'b1);
      check({23'h0, short_read_only}, 24'h1);
      sro(1'b0, 1'b1);
      check({23'h0, short_read_only}, 24'h0);
      rd(v);
      check({8'h0, v}, 24'h009abc);
      $display("data space test done");
      cmd(OP_LATCH, 16'h4005);
      cmd(OP_WRITE, 16'habcd);
      cmd(OP_WRITE, 16'h00ef);
      cmd(OP_LATCH, 16'h4005);
      repeat (4) @(negedge ref_clk);
      check(prog_mem[5], 24'habcdef);
      rd(v);
      check({8'h0, v}, 24'h00abcd);
      rd(v);
      check({16'h0, v[7:0]}, 24'h0000ef);
      $display("program space test done");
      report_and_stop();
   end

   // cut a hang short
   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      report_and_stop();
   end
endmodule : host_dma_port_handshake_test
